// ==== verilog/dsb_cfg.svh ====
// Constants of the start-up sequencer and bus protection block
`ifndef DSB_CFG_SVH
`define DSB_CFG_SVH

// -------------------------------------------------------------------------
// Widths
// -------------------------------------------------------------------------
`define DSB_WORD_W        16
`define DSB_INDEX_W       10
`define DSB_SLOT_W        4
`define DSB_SLOTS         10

// -------------------------------------------------------------------------
// Parameter indices
// -------------------------------------------------------------------------
`define DSB_IDX_SEQ_CTRL  10'h014
`define DSB_IDX_PD_CFG    10'h015
`define DSB_IDX_OV_LIM    10'h0e4
`define DSB_IDX_UV_LIM    10'h0e5
`define DSB_IDX_SH_THR    10'h0e6
`define DSB_IDX_SH_CFG    10'h0e7
`define DSB_IDX_EXT_RES   10'h0e8
`define DSB_IDX_EXT_PWR   10'h0e9
`define DSB_IDX_EXT_IND   10'h0ea
`define DSB_IDX_ME_START  10'h342

// -------------------------------------------------------------------------
// Storage slots
// -------------------------------------------------------------------------
`define DSB_SLOT_SEQ_CTRL 4'h0
`define DSB_SLOT_PD_CFG   4'h1
`define DSB_SLOT_OV_LIM   4'h2
`define DSB_SLOT_UV_LIM   4'h3
`define DSB_SLOT_SH_THR   4'h4
`define DSB_SLOT_SH_CFG   4'h5
`define DSB_SLOT_EXT_RES  4'h6
`define DSB_SLOT_EXT_PWR  4'h7
`define DSB_SLOT_EXT_IND  4'h8
`define DSB_SLOT_ME_START 4'h9

// -------------------------------------------------------------------------
// Field positions
// -------------------------------------------------------------------------
`define DSB_SEQ_BRIDGE_OFF 0
`define DSB_SEQ_LOAD_CFG   1
`define DSB_SEQ_PHASE      2
`define DSB_SEQ_SET_POS    3
`define DSB_SEQ_ENGINE_EN  4
`define DSB_ME_MODE_LO     0
`define DSB_ME_MODE_HI     2
`define DSB_ME_TRIG_LO     3
`define DSB_ME_TRIG_HI     4
`define DSB_ME_INDEX_LO    5
`define DSB_ME_INDEX_HI    8
`define DSB_ME_AUTO_LO     9
`define DSB_ME_AUTO_HI     15

// -------------------------------------------------------------------------
// Field values and reset values
// -------------------------------------------------------------------------
`define DSB_PD_IMMEDIATE  16'h0000
`define DSB_PD_DEFERRED   16'h0001
`define DSB_MODE_INDEXER  3'h0
`define DSB_AUTO_START    7'h01
`define DSB_SHUNT_ON      16'h0000
`define DSB_SHUNT_OFF     16'h0002
`define DSB_RESET_WORD    16'h0000

`endif

// ==== verilog/dsb_pkg.sv ====
// Types shared by the start-up sequencer and its parameter store
`include "dsb_cfg.svh"

package dsb_pkg;
  typedef logic [`DSB_WORD_W-1:0]  dsb_word_t;
  typedef logic [`DSB_INDEX_W-1:0] dsb_index_t;
  typedef logic [`DSB_SLOT_W-1:0]  dsb_slot_t;

  typedef enum logic [3:0] {
    ST_FETCH_CTRL,
    ST_FETCH_PD,
    ST_FETCH_ME,
    ST_CAPTURE_ME,
    ST_BRIDGE,
    ST_LOAD,
    ST_PHASE,
    ST_SET_POS,
    ST_ENGINE,
    ST_RUN,
    ST_LATE_PHASE
  } dsb_state_e;
endpackage

// ==== verilog/dsb_mem_if.sv ====
// Port of the parameter store as seen by the sequencer
`timescale 1ns/1ns

interface dsb_mem_if;
  import dsb_pkg::*;
  logic      wr_en;
  logic      rd_en;
  dsb_slot_t slot;
  dsb_word_t wdata;
  dsb_word_t rdata;

  modport ctrl (output wr_en, output rd_en, output slot, output wdata,
                input rdata);
  modport store (input wr_en, input rd_en, input slot, input wdata,
                 output rdata);
endinterface

// ==== verilog/dsb_param_store.sv ====
// Retained parameter words with a registered read port
`timescale 1ns/1ns

module dsb_param_store (
  input  wire logic core_clk_in,
  input  wire logic reset_n_in,
  dsb_mem_if.store  mem
);
  import dsb_pkg::*;

  dsb_word_t words_reg [`DSB_SLOTS];

  // -----------------------------------------------------------------------
  // Storage
  // -----------------------------------------------------------------------
  // No reset on the words: they model non-volatile storage that survives
  // a reset, so the start-up sequence sees what the host stored before.
  always_ff @(posedge core_clk_in) begin
    if (mem.wr_en) begin
      words_reg[mem.slot] <= mem.wdata;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      mem.rdata <= `DSB_RESET_WORD;
    end else if (mem.rd_en) begin
      mem.rdata <= words_reg[mem.slot];
    end
  end
endmodule

// ==== verilog/dsb_startup_seq.sv ====
// Power-up sequencer, bus voltage protection and shunt control
//
// Overview of operation
// - Power-up reads control word bits 0..3 as steps
// - Bit 4 enables motion engine after sequence
// - Phase detect now, or at first bridge enable
// - Engine mode bits 0..2, zero is indexer
// - Trigger bits 3..4: inputs or network
// - Bits 5..8 give index loaded at power-up
// - Bits 9..15 equal one: automatic motion start
// - Shunt on when bus reaches enable threshold
// - Shunt config 00 enables, 02 disables
`timescale 1ns/1ns

module dsb_startup_seq (
  input  wire logic             core_clk_in,
  input  wire logic             reset_n_in,
  input  wire logic             param_wr_in,
  input  wire logic             param_rd_in,
  input  wire dsb_pkg::dsb_index_t param_index_in,
  input  wire dsb_pkg::dsb_word_t  param_wdata_in,
  output logic                  param_busy_out,
  output logic                  param_ack_out,
  output logic                  param_err_out,
  output dsb_pkg::dsb_word_t    param_rdata_out,
  output logic                  seq_done_out,
  output logic                  bridge_disable_out,
  input  wire logic             bridge_enable_in,
  output logic                  load_cfg_req_out,
  input  wire logic             load_cfg_done_in,
  output logic                  phase_req_out,
  input  wire logic             phase_done_in,
  output logic                  set_pos_req_out,
  input  wire logic             set_pos_done_in,
  output logic                  engine_enable_out,
  output logic [2:0]            engine_mode_out,
  output logic [1:0]            engine_trigger_out,
  output logic [3:0]            engine_index_out,
  output logic                  engine_start_out,
  input  wire logic             control_cycle_in,
  input  wire dsb_pkg::dsb_word_t  bus_voltage_unit_in,
  output logic                  over_voltage_out,
  output logic                  under_voltage_out,
  output logic                  protection_event_out,
  output logic                  shunt_on_out
);
  import dsb_pkg::*;

  dsb_mem_if mem ();

  dsb_state_e state_reg;
  dsb_word_t  seq_ctrl_reg;
  dsb_word_t  pd_cfg_reg;
  dsb_word_t  me_start_reg;
  dsb_word_t  ov_lim_reg;
  dsb_word_t  uv_lim_reg;
  dsb_word_t  sh_thr_reg;
  dsb_word_t  sh_cfg_reg;
  logic       late_phase_reg;
  logic       bridge_en_prev_reg;
  logic       host_err_reg;
  logic       host_ok;
  logic       host_req;
  dsb_slot_t  host_slot;
  logic       ov_next;
  logic       uv_next;

  dsb_param_store store_u (
    .core_clk_in (core_clk_in),
    .reset_n_in  (reset_n_in),
    .mem         (mem.store)
  );

  // -----------------------------------------------------------------------
  // Parameter access
  // -----------------------------------------------------------------------
  function automatic logic index_valid(input dsb_index_t idx);
    case (idx)
      `DSB_IDX_SEQ_CTRL, `DSB_IDX_PD_CFG, `DSB_IDX_OV_LIM,
      `DSB_IDX_UV_LIM, `DSB_IDX_SH_THR, `DSB_IDX_SH_CFG,
      `DSB_IDX_EXT_RES, `DSB_IDX_EXT_PWR, `DSB_IDX_EXT_IND,
      `DSB_IDX_ME_START: index_valid = 1'b1;
      default:           index_valid = 1'b0;
    endcase
  endfunction

  function automatic dsb_slot_t index_slot(input dsb_index_t idx);
    case (idx)
      `DSB_IDX_PD_CFG:   index_slot = `DSB_SLOT_PD_CFG;
      `DSB_IDX_OV_LIM:   index_slot = `DSB_SLOT_OV_LIM;
      `DSB_IDX_UV_LIM:   index_slot = `DSB_SLOT_UV_LIM;
      `DSB_IDX_SH_THR:   index_slot = `DSB_SLOT_SH_THR;
      `DSB_IDX_SH_CFG:   index_slot = `DSB_SLOT_SH_CFG;
      `DSB_IDX_EXT_RES:  index_slot = `DSB_SLOT_EXT_RES;
      `DSB_IDX_EXT_PWR:  index_slot = `DSB_SLOT_EXT_PWR;
      `DSB_IDX_EXT_IND:  index_slot = `DSB_SLOT_EXT_IND;
      `DSB_IDX_ME_START: index_slot = `DSB_SLOT_ME_START;
      default:           index_slot = `DSB_SLOT_SEQ_CTRL;
    endcase
  endfunction

  // Store is single-ported; host waits while the sequence fetches
  assign param_busy_out = (state_reg == ST_FETCH_CTRL) ||
                          (state_reg == ST_FETCH_PD) ||
                          (state_reg == ST_FETCH_ME);
  assign host_req  = (param_wr_in || param_rd_in) && !param_busy_out;
  assign host_ok   = host_req && index_valid(param_index_in);
  assign host_slot = index_slot(param_index_in);

  // Shunt resistor words live only in the store and read back
  always_comb begin
    mem.wr_en = host_ok && param_wr_in;
    mem.rd_en = 1'b0;
    mem.slot  = host_slot;
    mem.wdata = param_wdata_in;
    case (state_reg)
      ST_FETCH_CTRL: begin
        mem.rd_en = 1'b1;
        mem.slot  = `DSB_SLOT_SEQ_CTRL;
      end
      ST_FETCH_PD: begin
        mem.rd_en = 1'b1;
        mem.slot  = `DSB_SLOT_PD_CFG;
      end
      ST_FETCH_ME: begin
        mem.rd_en = 1'b1;
        mem.slot  = `DSB_SLOT_ME_START;
      end
      default: mem.rd_en = host_ok && param_rd_in && !param_wr_in;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      param_ack_out <= 1'b0;
      host_err_reg  <= 1'b0;
    end else begin
      param_ack_out <= host_req;
      host_err_reg  <= host_req && !index_valid(param_index_in);
    end
  end

  assign param_err_out   = param_ack_out && host_err_reg;
  assign param_rdata_out = host_err_reg ? `DSB_RESET_WORD : mem.rdata;

  // Live copies of the words the protection logic compares on each control cycle
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      ov_lim_reg <= `DSB_RESET_WORD;
      uv_lim_reg <= `DSB_RESET_WORD;
      sh_thr_reg <= `DSB_RESET_WORD;
      sh_cfg_reg <= `DSB_SHUNT_OFF;
    end else if (mem.wr_en) begin
      case (host_slot)
        `DSB_SLOT_OV_LIM: ov_lim_reg <= param_wdata_in;
        `DSB_SLOT_UV_LIM: uv_lim_reg <= param_wdata_in;
        `DSB_SLOT_SH_THR: sh_thr_reg <= param_wdata_in;
        `DSB_SLOT_SH_CFG: sh_cfg_reg <= param_wdata_in;
        default: ;
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // Power-up sequence
  // -----------------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      state_reg      <= ST_FETCH_CTRL;
      seq_ctrl_reg   <= `DSB_RESET_WORD;
      pd_cfg_reg     <= `DSB_RESET_WORD;
      me_start_reg   <= `DSB_RESET_WORD;
      late_phase_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_FETCH_CTRL: state_reg <= ST_FETCH_PD;
        ST_FETCH_PD: begin
          seq_ctrl_reg <= mem.rdata;
          state_reg    <= ST_FETCH_ME;
        end
        ST_FETCH_ME: begin
          pd_cfg_reg <= mem.rdata;
          state_reg  <= ST_CAPTURE_ME;
        end
        ST_CAPTURE_ME: begin
          me_start_reg <= mem.rdata;
          state_reg    <= ST_BRIDGE;
        end
        ST_BRIDGE: state_reg <= ST_LOAD;
        ST_LOAD: begin
          if (!seq_ctrl_reg[`DSB_SEQ_LOAD_CFG] || load_cfg_done_in) begin
            state_reg <= ST_PHASE;
          end
        end
        ST_PHASE: begin
          if (!seq_ctrl_reg[`DSB_SEQ_PHASE]) begin
            state_reg <= ST_SET_POS;
          end else if (pd_cfg_reg == `DSB_PD_DEFERRED) begin
            late_phase_reg <= 1'b1;
            state_reg      <= ST_SET_POS;
          end else if (phase_done_in) begin
            state_reg <= ST_SET_POS;
          end
        end
        ST_SET_POS: begin
          if (!seq_ctrl_reg[`DSB_SEQ_SET_POS] || set_pos_done_in) begin
            state_reg <= ST_ENGINE;
          end
        end
        ST_ENGINE: state_reg <= ST_RUN;
        ST_RUN: begin
          if (late_phase_reg && bridge_enable_in && !bridge_en_prev_reg) begin
            state_reg <= ST_LATE_PHASE;
          end
        end
        ST_LATE_PHASE: begin
          if (phase_done_in) begin
            late_phase_reg <= 1'b0;
            state_reg      <= ST_RUN;
          end
        end
        default: state_reg <= ST_FETCH_CTRL;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      bridge_en_prev_reg <= 1'b0;
    end else begin
      bridge_en_prev_reg <= bridge_enable_in;
    end
  end

  // Immediate phase detect only when configured for it
  assign phase_req_out = (state_reg == ST_LATE_PHASE) ||
                         ((state_reg == ST_PHASE) &&
                          seq_ctrl_reg[`DSB_SEQ_PHASE] &&
                          (pd_cfg_reg != `DSB_PD_DEFERRED));
  assign load_cfg_req_out = (state_reg == ST_LOAD) &&
                            seq_ctrl_reg[`DSB_SEQ_LOAD_CFG];
  assign set_pos_req_out  = (state_reg == ST_SET_POS) &&
                            seq_ctrl_reg[`DSB_SEQ_SET_POS];

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      bridge_disable_out <= 1'b0;
    end else if (state_reg == ST_BRIDGE &&
                 seq_ctrl_reg[`DSB_SEQ_BRIDGE_OFF]) begin
      bridge_disable_out <= 1'b1;
    end else if (bridge_enable_in) begin
      bridge_disable_out <= 1'b0;
    end
  end

  // -----------------------------------------------------------------------
  // Motion engine start-up
  // -----------------------------------------------------------------------
  // A reserved mode never enables the engine, so no unknown mode runs
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      seq_done_out       <= 1'b0;
      engine_enable_out  <= 1'b0;
      engine_mode_out    <= `DSB_MODE_INDEXER;
      engine_trigger_out <= 2'h0;
      engine_index_out   <= 4'h0;
      engine_start_out   <= 1'b0;
    end else begin
      engine_start_out <= 1'b0;
      if (state_reg == ST_ENGINE) begin
        seq_done_out       <= 1'b1;
        engine_mode_out    <= me_start_reg[`DSB_ME_MODE_HI:`DSB_ME_MODE_LO];
        engine_trigger_out <= me_start_reg[`DSB_ME_TRIG_HI:`DSB_ME_TRIG_LO];
        engine_index_out   <= me_start_reg[`DSB_ME_INDEX_HI:`DSB_ME_INDEX_LO];
        engine_enable_out  <= seq_ctrl_reg[`DSB_SEQ_ENGINE_EN] &&
            (me_start_reg[`DSB_ME_MODE_HI:`DSB_ME_MODE_LO] ==
             `DSB_MODE_INDEXER);
        engine_start_out   <= seq_ctrl_reg[`DSB_SEQ_ENGINE_EN] &&
            (me_start_reg[`DSB_ME_MODE_HI:`DSB_ME_MODE_LO] ==
             `DSB_MODE_INDEXER) &&
            (me_start_reg[`DSB_ME_AUTO_HI:`DSB_ME_AUTO_LO] ==
             `DSB_AUTO_START);
      end
    end
  end

  // -----------------------------------------------------------------------
  // Bus voltage protection and shunt
  // -----------------------------------------------------------------------
  // Limits are signed; host keeps them inside the hardware window
  assign ov_next = $signed(bus_voltage_unit_in) > $signed(ov_lim_reg);
  assign uv_next = $signed(bus_voltage_unit_in) < $signed(uv_lim_reg);

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      over_voltage_out     <= 1'b0;
      under_voltage_out    <= 1'b0;
      protection_event_out <= 1'b0;
      shunt_on_out         <= 1'b0;
    end else begin
      protection_event_out <= 1'b0;
      if (control_cycle_in) begin
        over_voltage_out     <= ov_next;
        under_voltage_out    <= uv_next;
        protection_event_out <= (ov_next && !over_voltage_out) ||
                                (uv_next && !under_voltage_out);
        shunt_on_out <= (sh_cfg_reg == `DSB_SHUNT_ON) &&
            ($signed(bus_voltage_unit_in) >= $signed(sh_thr_reg));
      end
    end
  end

  // -----------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);

  seq_order_a: assert property (state_reg == ST_FETCH_CTRL |=>
      state_reg == ST_FETCH_PD ##1 state_reg == ST_FETCH_ME)
    else $error("fetch order broken");
  load_req_a: assert property ((state_reg == ST_LOAD) &&
      seq_ctrl_reg[`DSB_SEQ_LOAD_CFG] && !load_cfg_done_in |=>
      state_reg == ST_LOAD)
    else $error("load left before done");
  engine_en_a: assert property ((state_reg == ST_ENGINE) &&
      seq_ctrl_reg[`DSB_SEQ_ENGINE_EN] &&
      me_start_reg[2:0] == 3'h0 |=> engine_enable_out)
    else $error("engine not enabled");
  phase_defer_a: assert property ((state_reg == ST_PHASE) &&
      pd_cfg_reg == `DSB_PD_DEFERRED |-> !phase_req_out)
    else $error("deferred phase detect ran early");
  mode_reserved_a: assert property ((state_reg == ST_ENGINE) &&
      me_start_reg[2:0] != 3'h0 |=> !engine_enable_out)
    else $error("reserved mode enabled engine");
  index_load_a: assert property (state_reg == ST_ENGINE |=>
      engine_index_out == $past(me_start_reg[8:5]) &&
      engine_trigger_out == $past(me_start_reg[4:3]))
    else $error("index or trigger not loaded");
  auto_start_a: assert property (engine_start_out |->
      engine_enable_out && $past(me_start_reg[15:9]) == 7'h01)
    else $error("automatic start without cause");
  shunt_off_a: assert property (control_cycle_in &&
      sh_cfg_reg == `DSB_SHUNT_OFF |=> !shunt_on_out)
    else $error("shunt on while disabled");
  ov_flag_a: assert property (control_cycle_in &&
      $signed(bus_voltage_unit_in) > $signed(ov_lim_reg) |=>
      over_voltage_out)
    else $error("over-voltage missed");
  uv_flag_a: assert property (control_cycle_in &&
      $signed(bus_voltage_unit_in) < $signed(uv_lim_reg) |=>
      under_voltage_out)
    else $error("under-voltage missed");

  seq_done_c: cover property (state_reg == ST_ENGINE ##1 engine_start_out);
  late_phase_c: cover property (state_reg == ST_LATE_PHASE);
  shunt_c: cover property (shunt_on_out);
  prot_c: cover property (protection_event_out);
endmodule

// ==== testbench/dsb_host_model.sv ====
// Network host model that writes and reads drive parameters
`timescale 1ns/1ns
`include "dsb_cfg.svh"

module dsb_host_model #(
  parameter logic [15:0] NOMINAL = 16'h0190
) (
  input  wire logic               core_clk_in,
  input  wire logic               busy_in,
  input  wire logic               ack_in,
  input  wire logic               err_in,
  input  wire dsb_pkg::dsb_word_t rdata_in,
  output logic                    wr_out,
  output logic                    rd_out,
  output dsb_pkg::dsb_index_t     index_out,
  output dsb_pkg::dsb_word_t      wdata_out
);
  import dsb_pkg::*;

  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    index_out = 10'h000;
    wdata_out = 16'h0000;
  end

  // ---------------------------------------------------------------
  // One access: request held across the taking edge only
  // ---------------------------------------------------------------
  task automatic xfer(input logic w, input dsb_index_t idx,
                      input dsb_word_t d, output dsb_word_t q,
                      output logic e, output logic a);
    int n;
    n = 0;
    @(negedge core_clk_in);
    while (busy_in !== 1'b0 && n < 50) begin
      n++;
      @(negedge core_clk_in);
    end
    wr_out = w;
    rd_out = !w;
    index_out = idx;
    wdata_out = d;
    @(negedge core_clk_in);
    a = ack_in;
    e = err_in;
    q = rdata_in;
    wr_out = 1'b0;
    rd_out = 1'b0;
    // Stale bus must not look like a valid request
    index_out = ~idx;
    wdata_out = ~d;
  endtask

  // Limits always straddle the nominal bus level
  task automatic set_limits(input dsb_word_t above, input dsb_word_t below);
    dsb_word_t q;
    logic      e;
    logic      a;
    xfer(1'b1, `DSB_IDX_OV_LIM, NOMINAL + above + 16'h0001, q, e, a);
    xfer(1'b1, `DSB_IDX_UV_LIM, NOMINAL - below - 16'h0001, q, e, a);
  endtask
endmodule

// ==== testbench/drive_startup_and_bus_protection_bench.sv ====
// Self-checking bench of the start-up sequencer and bus protection
`timescale 1ns/1ns
`include "dsb_cfg.svh"

module drive_startup_and_bus_protection_bench;
  import dsb_pkg::*;
  localparam logic [15:0] NOM = 16'h0190;
  logic core_clk_in, reset_n_in, wr, rd, busy, ack, err, done, bdis, ben;
  logic lreq, ldone, preq, pdone, sreq, sdone, een, start, cyc;
  logic ovf, uvf, pev, shon, e, a;
  logic [2:0] emode;
  logic [1:0] etrig;
  logic [3:0] eidx;
  logic [3:1] seen;
  dsb_index_t idx;
  dsb_word_t  wd, rdat, vbus, q, ov_lim, uv_lim, thr, cfg;
  dsb_word_t  wv [10];
  int err_count, cmp_count, cycles, last_step;
  dsb_index_t tab [10] = '{`DSB_IDX_SEQ_CTRL, `DSB_IDX_PD_CFG,
    `DSB_IDX_OV_LIM, `DSB_IDX_UV_LIM, `DSB_IDX_SH_THR, `DSB_IDX_SH_CFG,
    `DSB_IDX_EXT_RES, `DSB_IDX_EXT_PWR, `DSB_IDX_EXT_IND,
    `DSB_IDX_ME_START};

  dsb_startup_seq DUT (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
    .param_wr_in(wr), .param_rd_in(rd), .param_index_in(idx),
    .param_wdata_in(wd), .param_busy_out(busy), .param_ack_out(ack),
    .param_err_out(err), .param_rdata_out(rdat), .seq_done_out(done),
    .bridge_disable_out(bdis), .bridge_enable_in(ben),
    .load_cfg_req_out(lreq), .load_cfg_done_in(ldone),
    .phase_req_out(preq), .phase_done_in(pdone),
    .set_pos_req_out(sreq), .set_pos_done_in(sdone),
    .engine_enable_out(een), .engine_mode_out(emode),
    .engine_trigger_out(etrig), .engine_index_out(eidx),
    .engine_start_out(start), .control_cycle_in(cyc),
    .bus_voltage_unit_in(vbus), .over_voltage_out(ovf),
    .under_voltage_out(uvf), .protection_event_out(pev),
    .shunt_on_out(shon));

  dsb_host_model #(.NOMINAL(NOM)) host (.core_clk_in(core_clk_in),
    .busy_in(busy), .ack_in(ack), .err_in(err), .rdata_in(rdat),
    .wr_out(wr), .rd_out(rd), .index_out(idx), .wdata_out(wd));

  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  // ---------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------
  task automatic chk1(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %b", $time, what, got);
    end
  endtask

  task automatic chk16(input dsb_word_t got, input dsb_word_t exp,
                       input string what);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h", $time, what, got);
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      report_and_stop;
    end
  end

  // Drive-side helpers finish each step after a random delay
  always @(negedge core_clk_in) begin
    ldone <= lreq && $urandom_range(0, 2) == 0;
    pdone <= preq && $urandom_range(0, 2) == 0;
    sdone <= sreq && $urandom_range(0, 2) == 0;
  end

  task automatic note_step(input int s);
    chk1(s >= last_step, 1'b1, "step order");
    last_step = s;
    seen[s] = 1'b1;
  endtask

  always @(posedge core_clk_in) begin
    if (lreq === 1'b1) note_step(1);
    if (preq === 1'b1) note_step(2);
    if (sreq === 1'b1) note_step(3);
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic run_seq(input dsb_word_t ctrl, input dsb_word_t pd,
                         input dsb_word_t me);
    int n;
    host.xfer(1'b1, `DSB_IDX_SEQ_CTRL, ctrl, q, e, a);
    host.xfer(1'b1, `DSB_IDX_PD_CFG, pd, q, e, a);
    host.xfer(1'b1, `DSB_IDX_ME_START, me, q, e, a);
    @(negedge core_clk_in);
    reset_n_in = 1'b0;
    @(negedge core_clk_in);
    reset_n_in = 1'b1;
    // Cleared after the reset edge so a pending late request is not counted
    seen = 3'b000;
    last_step = 0;
    chk1(busy, 1'b1, "busy in fetch");
    n = 0;
    while (done !== 1'b1 && n < 300) begin
      n++;
      @(negedge core_clk_in);
    end
    chk1(done, 1'b1, "sequence done");
    chk1(een, ctrl[4] && me[2:0] == 3'h0, "engine enable");
    chk1(start, ctrl[4] && me[2:0] == 3'h0 && me[15:9] == 7'h01,
         "auto start");
    chk1(bdis, ctrl[0], "bridge off");
    chk16({7'h00, eidx, etrig, emode}, {7'h00, me[8:0]},
          "engine fields");
    chk16({13'h0000, seen}, {13'h0000, ctrl[3], ctrl[2] && pd == 16'h0000,
          ctrl[1]}, "steps run");
    @(negedge core_clk_in);
    chk1(start, 1'b0, "start pulse");
    seen = 3'b000;
    last_step = 0;
    ben = 1'b1;
    repeat (2) @(negedge core_clk_in);
    chk1(bdis, 1'b0, "bridge enabled");
    repeat (24) @(negedge core_clk_in);
    chk1(seen[2], ctrl[2] && pd == 16'h0001, "late phase");
    ben = 1'b0;
  endtask

  task automatic prot(input dsb_word_t v);
    logic ov_e, uv_e, ov_o, uv_o;
    ov_o = ovf;
    uv_o = uvf;
    ov_e = $signed(v) > $signed(ov_lim);
    uv_e = $signed(v) < $signed(uv_lim);
    vbus = v;
    cyc = 1'b1;
    @(negedge core_clk_in);
    cyc = 1'b0;
    vbus = ~v;
    chk1(ovf, ov_e, "over");
    chk1(uvf, uv_e, "under");
    chk1(pev, (ov_e && !ov_o) || (uv_e && !uv_o), "event");
    chk1(shon, cfg == 16'h0000 && $signed(v) >= $signed(thr),
         "shunt");
    @(negedge core_clk_in);
    chk1(ovf, ov_e, "no strobe");
  endtask

  initial begin
    dsb_word_t v;
    dsb_word_t me;
    dsb_word_t cr [6];
    reset_n_in = 1'b0;
    ben = 1'b0;
    cyc = 1'b0;
    vbus = 16'h0000;
    ldone = 1'b0;
    pdone = 1'b0;
    sdone = 1'b0;
    void'($urandom(32'h6ea1));
    repeat (20) @(negedge core_clk_in);
    reset_n_in = 1'b1;
    for (int i = 0; i < 10; i++) begin
      wv[i] = 16'($urandom);
      host.xfer(1'b1, tab[i], wv[i], q, e, a);
      chk1(a, 1'b1, "write ack");
    end
    for (int i = 0; i < 10; i++) begin
      host.xfer(1'b0, tab[i], 16'h0000, q, e, a);
      chk1(a, 1'b1, "read ack");
      chk1(e, 1'b0, "read error");
      chk16(q, wv[i], "readback");
    end
    host.xfer(1'b0, 10'h016, 16'h0000, q, e, a);
    chk1(e, 1'b1, "unmapped error");
    chk16(q, 16'h0000, "unmapped data");
    $display("test parameter store done");
    for (int i = 0; i < 14; i++) begin
      me = 16'($urandom);
      me[15:9] = 7'($urandom_range(0, 2));
      if ($urandom_range(0, 3) != 0) me[2:0] = 3'h0;
      if (i == 0) run_seq(16'h0010, 16'h0000, 16'h0200);
      else if (i == 1) run_seq(16'hffff, 16'h0001, 16'h0201);
      else if (i == 2) run_seq(16'h001f, 16'h0000, 16'h0410);
      else run_seq(16'($urandom), 16'($urandom_range(0, 1)), me);
    end
    $display("test start-up sequence done");
    for (int c = 0; c < 2; c++) begin
      cfg = (c == 0) ? `DSB_SHUNT_ON : `DSB_SHUNT_OFF;
      thr = NOM + 16'($urandom_range(0, 99));
      ov_lim = NOM + 16'h0001 + 16'h00c8;
      uv_lim = NOM - 16'h0001 - 16'h0064;
      host.set_limits(16'h00c8, 16'h0064);
      host.xfer(1'b1, `DSB_IDX_SH_CFG, cfg, q, e, a);
      host.xfer(1'b1, `DSB_IDX_SH_THR, thr, q, e, a);
      cr = '{ov_lim, ov_lim + 16'h0001, uv_lim, uv_lim - 16'h0001,
             thr, thr - 16'h0001};
      for (int k = 0; k < 30; k++) begin
        v = (k < 6) ? cr[k] : NOM + 16'($urandom_range(0, 800)) - 16'h0190;
        prot(v);
      end
    end
    $display("test bus protection done");
    report_and_stop;
  end
endmodule
